// file: design/drive_status_monitor_params.svh
// constants for the drive status monitor
`ifndef DRIVE_STATUS_MONITOR_PARAMS_SVH
`define DRIVE_STATUS_MONITOR_PARAMS_SVH
// ==========================================
// wishbone register offsets (byte addresses)
`define OFS_FREQ_ARR1 8'h00
`define OFS_FREQ_ARR2 8'h04
`define OFS_ZERO_CUR 8'h08
`define OFS_OVER_CUR 8'h0C
`define OFS_CUR_ARR1 8'h10
`define OFS_CUR_ARR2 8'h14
`define OFS_RUN_TIMER 8'h18
`define OFS_ANALOG_LIM 8'h1C
`define OFS_TEMP 8'h20
`define OFS_WAKE 8'h24
`define OFS_HIB 8'h28
`define OFS_FLAGS 8'h2C
`define OFS_REMAIN 8'h30
`define OFS_FREQ_MAX 8'h34
// ==========================================
// field positions
`define POS_WIDTH 16
`define POS_DELAY 16
`define POS_HIGH 16
`define POS_FAN_TEMP 8
`define POS_FAN_MODE 16
`define POS_SRC 16
`define POS_TIMER_EN 18
`define POS_REG_STOP 19
// ==========================================
// reset values (0.01 Hz, 0.1 %, 0.01 s, 0.1 min, 0.01 V, degC, 0.1 s)
`define RST_FREQ_LEVEL 16'h1388
`define RST_FREQ_MAX 16'h1388
`define RST_ZERO_LEVEL 16'h0032
`define RST_ZERO_DELAY 16'h000A
`define RST_OVER_THR 16'h07D0
`define RST_OVER_DELAY 16'h0000
`define RST_CUR_LEVEL 16'h03E8
`define RST_LOW_LIM 16'h0136
`define RST_HIGH_LIM 16'h02A8
`define RST_MOD_TEMP 8'h4B
`define RST_FAN_TEMP 8'h28
// ==========================================
// timing: 250 MHz core clock, 10 ms tick for 0.01 s fields
`define CLK_HZ 250000000
`define TICK_10MS_SEC_DIV 100
`define TICK_10MS_CYCLES (`CLK_HZ / `TICK_10MS_SEC_DIV)
`define TICKS_PER_100MS 10
`define TICKS_PER_6S 600
`define RUN_LIMIT_MAX 16'hFDE8
`endif

// file: design/drive_status_monitor_pkg.sv
// types for the drive status monitor
package drive_status_monitor_pkg;
	typedef struct packed {
		logic [15:0] out_freq;
		logic [15:0] freq_ref;
		logic [15:0] out_current;
		logic [15:0] analog_input_one;
		logic [15:0] analog_input_two;
		logic [15:0] analog_input_three;
		logic [7:0] heatsink_temp;
		logic running;
		logic run_cmd;
		logic start;
		logic pid_ref;
	} measure_t;
	typedef struct packed {
		logic freq_arrival1;
		logic freq_arrival2;
		logic zero_current;
		logic overcurrent;
		logic current_arrival1;
		logic current_arrival2;
		logic timer_reached;
		logic analog_out_of_range;
		logic module_overheat;
		logic fan_on;
		logic hibernating;
		logic stop_request;
		logic regulator_enable;
	} flags_t;
	typedef enum logic [2:0] {
		HIB_RUN = 3'b001,
		HIB_SLEEP = 3'b010,
		HIB_IDLE = 3'b100
	} hib_state_t;
endpackage

// file: design/drive_status_monitor.sv
// drive status monitor: detectors, run timer, fan and hibernate control
// What this block does
// RULE1: frequency arrival when within level plus minus width
// RULE2: two independent frequency arrival detectors
// RULE3: zero current after delay at or below level
// RULE4: overcurrent after delay at threshold; zero disables
// RULE5: current arrival when within level plus minus width
// RULE6: two independent current arrival detectors
// RULE7: run timer stops drive, flags timer reached
// RULE8: timer restarts each start; remaining time readable
// RULE9: limit from setting or analog input, scaled
// RULE10: limit in tenth minutes, up to 6500.0
// RULE11: analog one outside window flags out of range
// RULE12: module overheat at temperature threshold
// RULE13: fan mode zero: run, or stopped and hot
// RULE14: fan mode one: fan always on
// RULE15: hibernate after reference low for delay
// RULE16: wake after reference high for delay
// RULE17: both frequencies zero disables hibernation
// RULE18: software keeps wake at or above hibernate
// RULE19: regulator keeps computing asleep only if selected
// RULE20: delay counters clear when condition drops
// RULE21: window edges inside; outputs low otherwise
`timescale 1ns/1ps
`include "drive_status_monitor_params.svh"
module drive_status_monitor
	import drive_status_monitor_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_10MS_CYCLES,
	parameter int DELAY_W = 20,
	parameter int RUN_W = 20
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// measurements from the power stage and analog channels
	input wire measure_t meas,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// terminal flags and run requests
	output flags_t flags
);
	typedef struct packed {
		logic [15:0] fa1_level, fa1_width, fa2_level, fa2_width, freq_max;
		logic [15:0] zc_level, zc_delay, oc_thr, oc_delay;
		logic [15:0] ca1_level, ca1_width, ca2_level, ca2_width;
		logic [15:0] run_setting;
		logic [1:0] run_src;
		logic run_timer_enable;
		logic regulator_in_stop_select;
		logic [15:0] low_lim, high_lim;
		logic [7:0] mod_temp, fan_temp;
		logic fan_mode;
		logic [15:0] wake_freq, wake_delay, hib_freq, hib_delay;
		logic [31:0] tick_cnt;
		logic tick;
		logic [DELAY_W-1:0] zc_cnt, oc_cnt;
		logic [RUN_W-1:0] hib_cnt;
		logic [RUN_W-1:0] run_ticks;
		logic [15:0] run_elapsed;
		logic [15:0] remaining;
		logic timer_done;
		hib_state_t hib;
		logic [31:0] rdata;
		logic ack;
		flags_t flags;
	} state_t;

	state_t q, d;

	// ==========================================
	// helpers
	function automatic logic in_window(input logic [15:0] val, input logic [15:0] lvl,
		input logic [15:0] wid);
		logic [17:0] lo, hi;
		lo = {2'b00, lvl} - {2'b00, wid};
		hi = {2'b00, lvl} + {2'b00, wid};
		// edges count as inside
		in_window = ($signed(lo) <= $signed({2'b00, val})) && ({2'b00, val} <= hi); // RULE21
	endfunction

	function automatic logic [15:0] pct_of_max(input logic [15:0] pct, input logic [15:0] fmax);
		logic [31:0] p;
		p = 32'(pct) * 32'(fmax);
		pct_of_max = 16'(p / 32'd1000);
	endfunction

	function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] dat,
		input logic [3:0] sel, input logic hi);
		logic [15:0] r;
		r = old;
		if (sel[hi ? 2 : 0]) r[7:0] = hi ? dat[23:16] : dat[7:0];
		if (sel[hi ? 3 : 1]) r[15:8] = hi ? dat[31:24] : dat[15:8];
		wr16 = r;
	endfunction

	// ==========================================
	// arrival windows, one generated comparator per detector
	localparam int N_ARRIVAL = 4;
	logic [15:0] arr_val [N_ARRIVAL];
	logic [15:0] arr_lvl [N_ARRIVAL];
	logic [15:0] arr_wid [N_ARRIVAL];
	wire [N_ARRIVAL-1:0] arr_hit;

	always_comb begin
		// slots 0 and 1 watch output frequency
		arr_val[0] = meas.out_freq;
		arr_val[1] = meas.out_freq;
		// slots 2 and 3 watch output current
		arr_val[2] = meas.out_current;
		arr_val[3] = meas.out_current;
		arr_lvl[0] = q.fa1_level;
		arr_lvl[1] = q.fa2_level;
		arr_lvl[2] = q.ca1_level;
		arr_lvl[3] = q.ca2_level;
		// frequency widths are tenths of a percent of max frequency
		arr_wid[0] = pct_of_max(q.fa1_width, q.freq_max);
		arr_wid[1] = pct_of_max(q.fa2_width, q.freq_max);
		// current widths share the level's units
		arr_wid[2] = q.ca1_width;
		arr_wid[3] = q.ca2_width;
	end

	// separate comparators keep the two sets independent
	for (genvar g = 0; g < N_ARRIVAL; g++) begin
		assign arr_hit[g] = in_window(arr_val[g], arr_lvl[g], arr_wid[g]); // RULE21
	end

	logic [15:0] run_limit;
	logic [15:0] ain_sel;
	logic [31:0] scaled;
	logic zc_cond, oc_cond, hib_low, hib_high, hib_off;
	logic [DELAY_W-1:0] zc_need, oc_need;
	logic [RUN_W-1:0] hib_need_lo, hib_need_hi;
	logic wr, rd;

	always_comb begin
		d = q;
		d.tick = 1'b0;
		d.ack = 1'b0;
		// ==========================================
		// 10 ms tick divider
		if (q.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
			d.tick_cnt = 32'h0;
			d.tick = 1'b1;
		end else begin
			d.tick_cnt = q.tick_cnt + 32'h1;
		end
		// ==========================================
		// frequency and current arrival, two sets each
		d.flags.freq_arrival1 = arr_hit[0]; // RULE1 RULE2
		d.flags.freq_arrival2 = arr_hit[1]; // RULE2
		d.flags.current_arrival1 = arr_hit[2]; // RULE5 RULE6
		d.flags.current_arrival2 = arr_hit[3]; // RULE6
		// ==========================================
		// delay-qualified current detectors
		zc_cond = meas.out_current <= q.zc_level;
		oc_cond = (q.oc_thr != 16'h0) && (meas.out_current >= q.oc_thr); // RULE4
		zc_need = DELAY_W'(q.zc_delay);
		oc_need = DELAY_W'(q.oc_delay);
		if (!zc_cond) begin
			d.zc_cnt = '0; // RULE20
			d.flags.zero_current = 1'b0;
		end else if (q.tick && q.zc_cnt <= zc_need) begin
			d.zc_cnt = q.zc_cnt + DELAY_W'(1);
		end
		if (zc_cond && q.zc_cnt > zc_need) d.flags.zero_current = 1'b1; // RULE3
		if (!oc_cond) begin
			d.oc_cnt = '0; // RULE20
			d.flags.overcurrent = 1'b0;
		end else if (q.tick && q.oc_cnt <= oc_need) begin
			d.oc_cnt = q.oc_cnt + DELAY_W'(1);
		end
		if (oc_cond && (q.oc_cnt > oc_need || q.oc_delay == 16'h0)) d.flags.overcurrent = 1'b1; // RULE4
		// ==========================================
		// analog window, overheat, fan
		d.flags.analog_out_of_range = (meas.analog_input_one > q.high_lim) ||
			(meas.analog_input_one < q.low_lim); // RULE11
		d.flags.module_overheat = meas.heatsink_temp >= q.mod_temp; // RULE12
		if (q.fan_mode) d.flags.fan_on = 1'b1; // RULE14
		else d.flags.fan_on = meas.running || (meas.heatsink_temp > q.fan_temp); // RULE13
		// ==========================================
		// run timer, 0.1 min units from the 10 ms tick
		unique case (q.run_src)
			2'd1: ain_sel = meas.analog_input_one;
			2'd2: ain_sel = meas.analog_input_two;
			2'd3: ain_sel = meas.analog_input_three;
			default: ain_sel = 16'hFFFF;
		endcase
		// full-scale analog maps to one below a nonzero stored setting
		scaled = 32'(ain_sel) * 32'(q.run_setting);
		run_limit = (q.run_src == 2'd0) ? q.run_setting : scaled[31:16]; // RULE9
		if (run_limit > `RUN_LIMIT_MAX) run_limit = `RUN_LIMIT_MAX; // RULE10
		if (meas.start) begin
			d.run_ticks = '0; // RULE8
			d.run_elapsed = 16'h0;
			d.timer_done = 1'b0;
		end else if (q.run_timer_enable && meas.running && q.tick && !q.timer_done) begin
			if (q.run_ticks == RUN_W'(`TICKS_PER_6S - 1)) begin
				d.run_ticks = '0;
				d.run_elapsed = q.run_elapsed + 16'h1; // RULE10
			end else begin
				d.run_ticks = q.run_ticks + RUN_W'(1);
			end
		end
		if (q.run_timer_enable && !meas.start && q.run_elapsed >= run_limit) d.timer_done = 1'b1; // RULE7
		if (!q.run_timer_enable) d.timer_done = 1'b0;
		d.remaining = (q.run_elapsed >= run_limit) ? 16'h0 : run_limit - q.run_elapsed; // RULE8
		d.flags.timer_reached = d.timer_done; // RULE7
		// ==========================================
		// hibernate and wake
		hib_off = (q.hib_freq == 16'h0) && (q.wake_freq == 16'h0); // RULE17
		hib_low = meas.freq_ref <= q.hib_freq;
		hib_high = meas.freq_ref >= q.wake_freq;
		// delays are 0.1 s, tick is 10 ms
		// a whole delay must pass despite tick phase; zero delay acts next cycle
		hib_need_lo = RUN_W'(32'(q.hib_delay) * `TICKS_PER_100MS);
		hib_need_hi = RUN_W'(32'(q.wake_delay) * `TICKS_PER_100MS);
		unique case (q.hib)
			HIB_IDLE: begin
				d.hib_cnt = '0;
				if (meas.running && !hib_off) d.hib = HIB_RUN;
			end
			HIB_RUN: begin
				if (!meas.running || hib_off || !hib_low) begin
					d.hib_cnt = '0; // RULE20
					if (!meas.running || hib_off) d.hib = HIB_IDLE;
				end else if (q.hib_cnt > hib_need_lo || q.hib_delay == 16'h0) begin
					d.hib_cnt = '0;
					d.hib = HIB_SLEEP; // RULE15
				end else if (q.tick) begin
					d.hib_cnt = q.hib_cnt + RUN_W'(1);
				end
			end
			HIB_SLEEP: begin
				if (!meas.run_cmd || hib_off) begin
					d.hib_cnt = '0;
					d.hib = HIB_IDLE;
				end else if (!hib_high) begin
					d.hib_cnt = '0; // RULE20
				end else if (q.hib_cnt > hib_need_hi || q.wake_delay == 16'h0) begin
					d.hib_cnt = '0;
					d.hib = HIB_RUN; // RULE16
				end else if (q.tick) begin
					d.hib_cnt = q.hib_cnt + RUN_W'(1);
				end
			end
			default: d.hib = HIB_IDLE;
		endcase
		d.flags.hibernating = (q.hib == HIB_SLEEP);
		d.flags.stop_request = d.timer_done || (q.hib == HIB_SLEEP); // RULE7
		// pid keeps running asleep only if selected
		d.flags.regulator_enable = !(meas.pid_ref && q.hib == HIB_SLEEP &&
			!q.regulator_in_stop_select); // RULE19
		// ==========================================
		// wishbone slave, one wait state, ack drops after one cycle
		// writes land on the edge at which the master sees ack
		wr = wb_cyc_i && wb_stb_i && wb_we_i && q.ack;
		rd = wb_cyc_i && wb_stb_i && !q.ack;
		if (rd) d.ack = 1'b1;
		if (wr) begin
			unique case (wb_adr_i)
				`OFS_FREQ_ARR1: begin
					d.fa1_level = wr16(q.fa1_level, wb_dat_i, wb_sel_i, 1'b0);
					d.fa1_width = wr16(q.fa1_width, wb_dat_i, wb_sel_i, 1'b1);
				end
				`OFS_FREQ_ARR2: begin
					d.fa2_level = wr16(q.fa2_level, wb_dat_i, wb_sel_i, 1'b0);
					d.fa2_width = wr16(q.fa2_width, wb_dat_i, wb_sel_i, 1'b1);
				end
				`OFS_ZERO_CUR: begin
					d.zc_level = wr16(q.zc_level, wb_dat_i, wb_sel_i, 1'b0);
					d.zc_delay = wr16(q.zc_delay, wb_dat_i, wb_sel_i, 1'b1);
				end
				`OFS_OVER_CUR: begin
					d.oc_thr = wr16(q.oc_thr, wb_dat_i, wb_sel_i, 1'b0);
					d.oc_delay = wr16(q.oc_delay, wb_dat_i, wb_sel_i, 1'b1);
				end
				`OFS_CUR_ARR1: begin
					d.ca1_level = wr16(q.ca1_level, wb_dat_i, wb_sel_i, 1'b0);
					d.ca1_width = wr16(q.ca1_width, wb_dat_i, wb_sel_i, 1'b1);
				end
				`OFS_CUR_ARR2: begin
					d.ca2_level = wr16(q.ca2_level, wb_dat_i, wb_sel_i, 1'b0);
					d.ca2_width = wr16(q.ca2_width, wb_dat_i, wb_sel_i, 1'b1);
				end
				`OFS_RUN_TIMER: begin
					d.run_setting = wr16(q.run_setting, wb_dat_i, wb_sel_i, 1'b0);
					if (wb_sel_i[2]) begin
						d.run_src = wb_dat_i[`POS_SRC+1:`POS_SRC];
						d.run_timer_enable = wb_dat_i[`POS_TIMER_EN];
						d.regulator_in_stop_select = wb_dat_i[`POS_REG_STOP];
					end
				end
				`OFS_ANALOG_LIM: begin
					d.low_lim = wr16(q.low_lim, wb_dat_i, wb_sel_i, 1'b0);
					d.high_lim = wr16(q.high_lim, wb_dat_i, wb_sel_i, 1'b1);
				end
				`OFS_TEMP: begin
					if (wb_sel_i[0]) d.mod_temp = wb_dat_i[7:0];
					if (wb_sel_i[1]) d.fan_temp = wb_dat_i[15:8];
					if (wb_sel_i[2]) d.fan_mode = wb_dat_i[`POS_FAN_MODE];
				end
				`OFS_WAKE: begin
					d.wake_freq = wr16(q.wake_freq, wb_dat_i, wb_sel_i, 1'b0);
					d.wake_delay = wr16(q.wake_delay, wb_dat_i, wb_sel_i, 1'b1);
				end
				`OFS_HIB: begin
					d.hib_freq = wr16(q.hib_freq, wb_dat_i, wb_sel_i, 1'b0);
					d.hib_delay = wr16(q.hib_delay, wb_dat_i, wb_sel_i, 1'b1);
				end
				`OFS_FREQ_MAX: d.freq_max = wr16(q.freq_max, wb_dat_i, wb_sel_i, 1'b0);
				default: ;
			endcase
		end
		// unmapped addresses read zero and still ack
		unique case (wb_adr_i)
			`OFS_FREQ_ARR1: d.rdata = {q.fa1_width, q.fa1_level};
			`OFS_FREQ_ARR2: d.rdata = {q.fa2_width, q.fa2_level};
			`OFS_ZERO_CUR: d.rdata = {q.zc_delay, q.zc_level};
			`OFS_OVER_CUR: d.rdata = {q.oc_delay, q.oc_thr};
			`OFS_CUR_ARR1: d.rdata = {q.ca1_width, q.ca1_level};
			`OFS_CUR_ARR2: d.rdata = {q.ca2_width, q.ca2_level};
			`OFS_RUN_TIMER: d.rdata = {12'h0, q.regulator_in_stop_select, q.run_timer_enable,
				q.run_src, q.run_setting};
			`OFS_ANALOG_LIM: d.rdata = {q.high_lim, q.low_lim};
			`OFS_TEMP: d.rdata = {15'h0, q.fan_mode, q.fan_temp, q.mod_temp};
			`OFS_WAKE: d.rdata = {q.wake_delay, q.wake_freq};
			`OFS_HIB: d.rdata = {q.hib_delay, q.hib_freq};
			`OFS_FLAGS: d.rdata = {19'h0, q.flags};
			`OFS_REMAIN: d.rdata = {16'h0, q.remaining}; // RULE8
			`OFS_FREQ_MAX: d.rdata = {16'h0, q.freq_max};
			default: d.rdata = 32'h0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			q <= '0;
			q.fa1_level <= `RST_FREQ_LEVEL;
			q.fa2_level <= `RST_FREQ_LEVEL;
			q.freq_max <= `RST_FREQ_MAX;
			q.zc_level <= `RST_ZERO_LEVEL;
			q.zc_delay <= `RST_ZERO_DELAY;
			q.oc_thr <= `RST_OVER_THR;
			q.oc_delay <= `RST_OVER_DELAY;
			q.ca1_level <= `RST_CUR_LEVEL;
			q.ca2_level <= `RST_CUR_LEVEL;
			q.low_lim <= `RST_LOW_LIM;
			q.high_lim <= `RST_HIGH_LIM;
			q.mod_temp <= `RST_MOD_TEMP;
			q.fan_temp <= `RST_FAN_TEMP;
			q.hib <= HIB_IDLE;
			q.flags.regulator_enable <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign wb_dat_o = q.rdata;
	assign wb_ack_o = q.ack;
	assign flags = q.flags;
endmodule

// file: tb/drive_meas_model.sv
// measurement source standing in for the power stage and analog channels
`timescale 1ns/1ps
module drive_meas_model
	import drive_status_monitor_pkg::*;
(
	// clock
	input wire logic core_clk,
	// values the bench wants reported
	input wire measure_t target,
	// sampled measurements toward the monitor
	output measure_t meas
);
	// ==========================================
	// sampling
	// one sample of lag, like a converter; never faster than real hardware
	always_ff @(posedge core_clk) begin
		meas <= target;
	end
endmodule

// file: tb/drive_status_monitor_props.sv
// port-level checker for the drive status monitor
`timescale 1ns/1ps
module drive_status_monitor_props
	import drive_status_monitor_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// measurements
	input wire measure_t meas,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// flags
	input wire flags_t flags
);
	// ==========================================
	// properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	AST_ACK_TIMELY: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
		else $error("ack without request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_FAN_RUN: assert property (meas.running |=> flags.fan_on)
		else $error("fan off while running");
	AST_STOP_REQ: assert property (flags.timer_reached || flags.hibernating |-> ##[0:1] flags.stop_request)
		else $error("no stop request");
	AST_HIB_ENTRY: assert property ($rose(flags.hibernating) |-> $past(meas.running && meas.run_cmd))
		else $error("hibernation entered while not running");
	AST_REG_EN: assert property (!flags.regulator_enable |-> flags.hibernating && $past(meas.pid_ref))
		else $error("regulator halted outside hibernation");
	AST_START_CLR: assert property (meas.start |=> !flags.timer_reached)
		else $error("timer flag kept across start");
endmodule
bind drive_status_monitor drive_status_monitor_props u_props (.core_clk(core_clk), .srst(srst),
	.meas(meas), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .flags(flags));

// file: tb/tb_drive_status_monitor.sv
// self-checking bench for the drive status monitor
`timescale 1ns/1ps
`include "drive_status_monitor_params.svh"
module tb_drive_status_monitor import drive_status_monitor_pkg::*;;
	// ==========================================
	// signals
	localparam int TICK = 10;
	localparam int TENTH = 600 * TICK;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [31:0] rd;
	measure_t tgt = '0;
	measure_t meas;
	flags_t flags;
	int num_errors = 0;
	int n_compared = 0;
	int ef [8] = '{1949, 1950, 2050, 2051, 3000, 2999, 3001, 2000};
	int ec [8] = '{979, 980, 1020, 1021, 500, 499, 501, 1000};
	int ea [8] = '{309, 310, 680, 681, 0, 1000, 495, 400};
	int et [8] = '{74, 75, 41, 39, 76, 0, 200, 60};
	logic [7:0] da [6] = '{`OFS_FREQ_ARR1, `OFS_ZERO_CUR, `OFS_OVER_CUR, `OFS_ANALOG_LIM,
		`OFS_TEMP, 8'h3C};
	logic [31:0] dv [6] = '{{16'h0000, `RST_FREQ_LEVEL}, {`RST_ZERO_DELAY, `RST_ZERO_LEVEL},
		{`RST_OVER_DELAY, `RST_OVER_THR}, {`RST_HIGH_LIM, `RST_LOW_LIM},
		{16'h0000, `RST_FAN_TEMP, `RST_MOD_TEMP}, 32'h0};
	always #2 core_clk = ~core_clk;
	drive_status_monitor #(.TICK_CYCLES(TICK)) u_dut (.core_clk(core_clk), .srst(srst),
		.meas(meas), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .flags(flags));
	drive_meas_model u_model (.core_clk(core_clk), .target(tgt), .meas(meas));
	// ==========================================
	// helpers
	task automatic report_and_stop();
		if (num_errors == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bail();
		num_errors++;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		report_and_stop();
	endtask
	// entered just after a rising edge; leaves one idle cycle behind
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		@(posedge core_clk);
		while (wb_ack_o !== 1'b1) begin
			n++;
			if (n > 50) bail();
			@(posedge core_clk);
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wait_flag(input int b, input logic v, input int lim, output int n);
		n = 0;
		while (flags[b] !== v) begin
			n++;
			if (n > lim) bail();
			@(posedge core_clk);
		end
	endtask
	function automatic logic in_win(input int v, input int c, input int w);
		return (v >= c - w) && (v <= c + w);
	endfunction
	// ==========================================
	// sequence
	initial begin
		int n;
		int fq;
		int cu;
		int an;
		int tp;
		logic rn;
		n = $urandom(54);
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		foreach (da[i]) begin
			wb_cycle(1'b0, da[i], 32'h0);
			check(rd, dv[i]);
		end
		wb_cycle(1'b1, `OFS_FREQ_ARR1, {16'h000A, 16'h07D0});
		wb_cycle(1'b1, `OFS_FREQ_ARR2, {16'h0000, 16'h0BB8});
		wb_cycle(1'b1, `OFS_CUR_ARR1, {16'h0014, 16'h03E8});
		wb_cycle(1'b1, `OFS_CUR_ARR2, {16'h0000, 16'h01F4});
		for (int i = 0; i < 48; i++) begin
			fq = (i < 8) ? ef[i] : 1940 + $urandom_range(120);
			cu = (i < 8) ? ec[i] : 450 + $urandom_range(650);
			an = (i < 8) ? ea[i] : $urandom_range(1000);
			tp = (i < 8) ? et[i] : $urandom_range(120);
			rn = $urandom_range(1);
			tgt.out_freq <= fq[15:0];
			tgt.out_current <= cu[15:0];
			tgt.analog_input_one <= an[15:0];
			tgt.heatsink_temp <= tp[7:0];
			tgt.running <= rn;
			repeat (4) @(posedge core_clk);
			check(flags.freq_arrival1, in_win(fq, 2000, 50));
			check(flags.freq_arrival2, in_win(fq, 3000, 0));
			check(flags.current_arrival1, in_win(cu, 1000, 20));
			check(flags.current_arrival2, in_win(cu, 500, 0));
			check(flags.analog_out_of_range, !in_win(an, 495, 185));
			check(flags.module_overheat, tp >= 75);
			if (tp != 40) check(flags.fan_on, rn || tp > 40);
		end
		tgt.running <= 1'b0;
		tgt.heatsink_temp <= 8'h14;
		wb_cycle(1'b1, `OFS_TEMP, {16'h0001, 16'h284B});
		repeat (3) @(posedge core_clk);
		check(flags.fan_on, 1'b1);
		wb_cycle(1'b1, `OFS_ZERO_CUR, {16'h0003, 16'h0064});
		tgt.out_current <= 16'h0064;
		wait_flag(10, 1'b1, 80, n);
		check(n >= 30, 1'b1);
		tgt.out_current <= 16'h0065;
		wait_flag(10, 1'b0, 5, n);
		wb_cycle(1'b1, `OFS_OVER_CUR, 32'h0);
		tgt.out_current <= 16'h0BB8;
		repeat (20) @(posedge core_clk);
		check(flags.overcurrent, 1'b0);
		wb_cycle(1'b1, `OFS_OVER_CUR, {16'h0000, 16'h05DC});
		tgt.out_current <= 16'h05DC;
		wait_flag(9, 1'b1, 5, n);
		tgt.out_current <= 16'h05DB;
		wait_flag(9, 1'b0, 5, n);
		for (int s = 0; s < 4; s++) begin
			// wrong channel would scale full scale to a longer limit
			tgt.analog_input_one <= (s == 1) ? 16'h8000 : 16'hFFFF;
			tgt.analog_input_two <= (s == 2) ? 16'h8000 : 16'hFFFF;
			tgt.analog_input_three <= (s == 3) ? 16'h8000 : 16'hFFFF;
			wb_cycle(1'b1, `OFS_RUN_TIMER, 32'h0004_0000 | (s << 16) | ((s == 0) ? 2 : 4));
			tgt.start <= 1'b1;
			tgt.running <= 1'b1;
			tgt.run_cmd <= 1'b1;
			@(posedge core_clk);
			tgt.start <= 1'b0;
			repeat (3) @(posedge core_clk);
			wb_cycle(1'b0, `OFS_REMAIN, 32'h0);
			check(rd, 32'h2);
			wait_flag(6, 1'b1, 2 * TENTH + 200, n);
			check(n > 2 * TENTH - 200, 1'b1);
			check(flags.stop_request, 1'b1);
			tgt.running <= 1'b0;
		end
		wb_cycle(1'b1, `OFS_RUN_TIMER, 32'h0);
		tgt.running <= 1'b1;
		tgt.pid_ref <= 1'b1;
		tgt.freq_ref <= 16'h05DC;
		wb_cycle(1'b1, `OFS_WAKE, {16'h0001, 16'h07D0});
		wb_cycle(1'b1, `OFS_HIB, {16'h0001, 16'h03E8});
		tgt.freq_ref <= 16'h03E8;
		wait_flag(2, 1'b1, 140, n);
		check(n >= 100, 1'b1);
		check(flags.regulator_enable, 1'b0);
		wb_cycle(1'b1, `OFS_RUN_TIMER, 32'h0008_0000);
		repeat (3) @(posedge core_clk);
		check(flags.regulator_enable, 1'b1);
		tgt.freq_ref <= 16'h07CF;
		repeat (150) @(posedge core_clk);
		check(flags.hibernating, 1'b1);
		tgt.freq_ref <= 16'h07D0;
		wait_flag(2, 1'b0, 140, n);
		check(n >= 100, 1'b1);
		wb_cycle(1'b1, `OFS_WAKE, 32'h0);
		wb_cycle(1'b1, `OFS_HIB, 32'h0);
		tgt.freq_ref <= 16'h0000;
		repeat (20) @(posedge core_clk);
		check(flags.hibernating, 1'b0);
		report_and_stop();
	end
endmodule
